// >>> core/wake_event_pkg.sv
// Constants for the wake-event and event-pin control slice.
// Assumes a 32-bit classic Wishbone register port and a 100 MHz system clock.
package wake_event_pkg;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned SEL_W      = 4;
    localparam int unsigned LANE_SHIFT = 3;
    localparam int unsigned NUM_SRC    = 3;

    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h08;

    localparam int unsigned BIT_MAC_GATE  = 18;
    localparam int unsigned BIT_HOST_EN   = 9;
    localparam int unsigned BIT_BUF_SEL   = 6;
    localparam int unsigned BIT_PULSE_SEL = 3;
    localparam int unsigned BIT_POLARITY  = 2;
    localparam int unsigned BIT_PIN_EN    = 1;
    localparam int unsigned BIT_WAKE_IRQ  = 0;
    // Source order: port A, port B, host MAC
    localparam int unsigned FLAG_BIT [NUM_SRC] = '{16, 17, 5};
    localparam int unsigned EN_BIT   [NUM_SRC] = '{14, 15, 9};

    localparam logic [DATA_W-1:0] CTRL_RSVD_MASK = 32'h0000_3D80;
    localparam logic [DATA_W-1:0] REG_RESET      = 32'h0000_0000;

    localparam int unsigned PULSE_TIME_MS = 50;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned PULSE_CYCLES  = PULSE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PIN_IDLE   = 3'b001,
        PIN_ASSERT = 3'b010,
        PIN_SPENT  = 3'b100
    } pin_state_t;
endpackage

// >>> core/pin_ctrl_if.sv
// Settings and request passed from the register slice to the event pin driver.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface pin_ctrl_if;
    logic request;
    logic pulseSel;
    logic polarity;
    logic pushPull;
    logic enable;
    logic asserted;

    modport drv (input request, input pulseSel, input polarity, input pushPull,
                 input enable, output asserted);
    modport ctl (output request, output pulseSel, output polarity, output pushPull,
                 output enable, input asserted);
endinterface

// >>> core/double_write_gate.sv
// Control bit that sets only after two back-to-back writes of one.
// Assumes wrEn pulses once per completed write to the owning register lane.
`timescale 1ns/10ps
module double_write_gate (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic wrEn,
    input  wire logic wrBit,
    output logic      gate_q
);
    logic armed_q;
    wire  armed_d = wrEn ? wrBit : armed_q;
    wire  gate_d  = wrEn ? (wrBit & (armed_q | gate_q)) : gate_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            armed_q <= 1'b0;
            gate_q  <= 1'b0;
        end
        else
        begin
            armed_q <= armed_d;
            gate_q  <= gate_d;
        end
    end

    a_gate_second_write : assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(gate_q) |-> $past(armed_q) && $past(wrEn) && $past(wrBit))
        else $error("Gate set without two consecutive writes of one");
    a_gate_zero_restart : assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrEn && !wrBit |=> !gate_q && !armed_q)
        else $error("Write of zero did not restart the gate count");
endmodule

// >>> core/event_pin_driver.sv
// Event pin sequencer: level or timed pulse, open-drain or push-pull drive.
// Assumes the request is a level that falls when flags or enables are cleared.
`timescale 1ns/10ps
module event_pin_driver #(
    parameter int unsigned PulseCycles = wake_event_pkg::PULSE_CYCLES
) (
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    pin_ctrl_if.drv    ctrl,
    output logic       pinOut_q,
    output logic       pinOe_q
);
    localparam int unsigned CNT_W = $clog2(PulseCycles + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PulseCycles);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);

    wake_event_pkg::pin_state_t state_q, state_d;
    logic [CNT_W-1:0] count_q, count_d;

    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            wake_event_pkg::PIN_IDLE:
                if (ctrl.request)
                begin
                    state_d = wake_event_pkg::PIN_ASSERT;
                    count_d = CNT_LOAD;
                end
            wake_event_pkg::PIN_ASSERT:
                if (!ctrl.request)
                    state_d = wake_event_pkg::PIN_IDLE;
                else if (ctrl.pulseSel && count_q <= CNT_LAST)
                    state_d = wake_event_pkg::PIN_SPENT;
                else if (ctrl.pulseSel)
                    count_d = count_q - CNT_LAST;
            wake_event_pkg::PIN_SPENT:
                if (!ctrl.request)
                    state_d = wake_event_pkg::PIN_IDLE;
            default:
                state_d = wake_event_pkg::PIN_IDLE;
        endcase
    end

    // Pin enable gates drive only; the sequencer keeps running underneath
    wire active = (state_q == wake_event_pkg::PIN_ASSERT) & ctrl.enable;
    wire outD   = ctrl.pushPull ? ~(active ^ ctrl.polarity) : 1'b0;
    wire oeD    = ctrl.pushPull | active;
    assign ctrl.asserted = (state_q == wake_event_pkg::PIN_ASSERT);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= wake_event_pkg::PIN_IDLE;
            count_q  <= '0;
            pinOut_q <= 1'b0;
            pinOe_q  <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            count_q  <= count_d;
            pinOut_q <= outD;
            pinOe_q  <= oeD;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_pin_drop_request : assert property (
        !ctrl.request |=> state_q == wake_event_pkg::PIN_IDLE)
        else $error("Pin sequencer held without a request");
    a_pin_level_hold : assert property (
        state_q == wake_event_pkg::PIN_ASSERT && !ctrl.pulseSel && ctrl.request
        |=> state_q == wake_event_pkg::PIN_ASSERT)
        else $error("Level mode released while request stands");
    a_pin_pulse_bound : assert property (
        state_q == wake_event_pkg::PIN_ASSERT && ctrl.pulseSel
        |-> count_q <= CNT_LOAD && count_q != '0)
        else $error("Pulse counter out of range");
    a_pin_push_high : assert property (
        ctrl.pushPull && ctrl.polarity && active |=> pinOut_q && pinOe_q)
        else $error("Active-high push-pull pin not driven high");
    a_pin_open_low : assert property (!ctrl.pushPull |=> !pinOut_q)
        else $error("Open-drain pin drives a high level");
endmodule

// >>> core/wake_event_pme_control.sv
// Wake-event register slice: MAC clock gate, wake flags, routing, event pin, interrupt.
// Assumes a classic Wishbone master and level wake events held until their source clears.
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module wake_event_pme_control #(
    parameter int unsigned PulseCycles = wake_event_pkg::PULSE_CYCLES
) (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire logic                                wb_cyc_i,
    input  wire logic                                wb_stb_i,
    input  wire logic                                wb_we_i,
    input  wire logic [wake_event_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [wake_event_pkg::SEL_W-1:0]    wb_sel_i,
    input  wire logic [wake_event_pkg::DATA_W-1:0]   wb_dat_i,
    output logic      [wake_event_pkg::DATA_W-1:0]   wb_dat_o,
    output logic                                     wb_ack_o,
    input  wire logic                                portAEvent,
    input  wire logic                                portBEvent,
    input  wire logic                                hostMacWakeEvent,
    output logic                                     macSysClkEn,
    output logic                                     macRxTxClkEn,
    output logic                                     wakeEventOut,
    output logic                                     wakeEventOe,
    output logic                                     irq
);
    localparam int unsigned DW = wake_event_pkg::DATA_W;
    localparam int unsigned NS = wake_event_pkg::NUM_SRC;

    // Address match, used by every register decode
    function automatic logic hit(input logic [wake_event_pkg::ADDR_W-1:0] adr,
                                 input logic [wake_event_pkg::ADDR_W-1:0] ofs);
        hit = (adr == ofs);
    endfunction

    // Byte lane that carries a given bit
    function automatic logic laneOn(input logic [wake_event_pkg::SEL_W-1:0] sel,
                                    input int unsigned bitPos);
        laneOn = sel[bitPos >> wake_event_pkg::LANE_SHIFT];
    endfunction

    logic          ack_q;
    logic [DW-1:0] rdData_q;
    logic [NS-1:0] enSrc_q;
    logic [NS-1:0] flag_q;
    logic [NS-1:0] routed_q;
    logic          bufSel_q;
    logic          pulseSel_q;
    logic          polarity_q;
    logic          pinEn_q;
    logic          wakeIrq_q;
    logic          irqMask_q;
    logic          irq_q;
    logic          sysClkEn_q;
    logic          rxTxClkEn_q;
    logic          macGate;
    logic          pinOut;
    logic          pinOe;
    logic [DW-1:0] ctrlRead;

    // Bus decode
    wire reqValid  = wb_cyc_i & wb_stb_i;
    wire ack_d     = reqValid & ~ack_q;
    // Writes land on the edge where the master samples ack
    wire wrFire    = reqValid & wb_we_i & ack_q;
    wire selCtrl   = hit(wb_adr_i, wake_event_pkg::OFS_CTRL);
    wire selStatus = hit(wb_adr_i, wake_event_pkg::OFS_STATUS);
    wire selMask   = hit(wb_adr_i, wake_event_pkg::OFS_MASK);
    wire wrCtrl    = wrFire & selCtrl;
    wire wrStatus  = wrFire & selStatus;
    wire wrMask    = wrFire & selMask;

    // Per-bit strobes for the control register
    wire wrGate     = wrCtrl & laneOn(wb_sel_i, wake_event_pkg::BIT_MAC_GATE);
    wire wrBufSel   = wrCtrl & laneOn(wb_sel_i, wake_event_pkg::BIT_BUF_SEL);
    wire wrPulseSel = wrCtrl & laneOn(wb_sel_i, wake_event_pkg::BIT_PULSE_SEL);
    wire wrPolarity = wrCtrl & laneOn(wb_sel_i, wake_event_pkg::BIT_POLARITY);
    wire wrPinEn    = wrCtrl & laneOn(wb_sel_i, wake_event_pkg::BIT_PIN_EN);

    wire bufSel_d   = wrBufSel ? wb_dat_i[wake_event_pkg::BIT_BUF_SEL] : bufSel_q;
    wire pulseSel_d = wrPulseSel ? wb_dat_i[wake_event_pkg::BIT_PULSE_SEL] : pulseSel_q;
    wire polarity_d = wrPolarity ? wb_dat_i[wake_event_pkg::BIT_POLARITY] : polarity_q;
    wire pinEn_d    = wrPinEn ? wb_dat_i[wake_event_pkg::BIT_PIN_EN] : pinEn_q;

    // Wake sources: port A, port B, host MAC
    wire [NS-1:0] srcEvent = {hostMacWakeEvent, portBEvent, portAEvent};
    logic [NS-1:0] enWr;
    logic [NS-1:0] enVal;
    logic [NS-1:0] clrReq;
    logic [NS-1:0] enSrc_d;
    logic [NS-1:0] flag_d;

    genvar g;
    generate
        for (g = 0; g < NS; g++)
        begin : gen_src
            localparam int unsigned FB = wake_event_pkg::FLAG_BIT[g];
            localparam int unsigned EB = wake_event_pkg::EN_BIT[g];
            assign enWr[g]    = wrCtrl & laneOn(wb_sel_i, EB);
            assign enVal[g]   = wb_dat_i[EB];
            assign clrReq[g]  = wrCtrl & laneOn(wb_sel_i, FB) & wb_dat_i[FB];
            assign enSrc_d[g] = enWr[g] ? enVal[g] : enSrc_q[g];
            // A live event keeps the flag set, so a clear only sticks once it is gone
            assign flag_d[g]  = srcEvent[g] | (flag_q[g] & ~clrReq[g]);
        end
    endgenerate

    // Routing into the wake interrupt flag
    wire [NS-1:0] routedNow  = flag_q & enSrc_q;
    wire [NS-1:0] routedRise = routedNow & ~routed_q;
    wire irqSet    = |routedRise;
    wire irqClr    = wrStatus & laneOn(wb_sel_i, wake_event_pkg::BIT_WAKE_IRQ)
                     & wb_dat_i[wake_event_pkg::BIT_WAKE_IRQ];
    // Set beats a simultaneous write-one clear
    wire wakeIrq_d = irqSet | (wakeIrq_q & ~irqClr);
    wire irqMask_d = (wrMask & laneOn(wb_sel_i, wake_event_pkg::BIT_WAKE_IRQ))
                     ? wb_dat_i[wake_event_pkg::BIT_WAKE_IRQ] : irqMask_q;
    wire irq_d     = wakeIrq_q & irqMask_q;

    // Read path; unmapped addresses read zero and still get ack
    always_comb
    begin
        ctrlRead = wake_event_pkg::REG_RESET;
        ctrlRead[wake_event_pkg::BIT_MAC_GATE]  = macGate;
        ctrlRead[wake_event_pkg::BIT_BUF_SEL]   = bufSel_q;
        ctrlRead[wake_event_pkg::BIT_PULSE_SEL] = pulseSel_q;
        ctrlRead[wake_event_pkg::BIT_POLARITY]  = polarity_q;
        ctrlRead[wake_event_pkg::BIT_PIN_EN]    = pinEn_q;
        for (int i = 0; i < NS; i++)
        begin
            ctrlRead[wake_event_pkg::FLAG_BIT[i]] = flag_q[i];
            ctrlRead[wake_event_pkg::EN_BIT[i]]   = enSrc_q[i];
        end
    end

    wire [DW-1:0] readMux = selCtrl   ? ctrlRead :
                            selStatus ? DW'(wakeIrq_q) :
                            selMask   ? DW'(irqMask_q) : wake_event_pkg::REG_RESET;
    wire [DW-1:0] rdData_d = (ack_d & ~wb_we_i) ? readMux : wake_event_pkg::REG_RESET;

    // MAC system clock gate with its two-write arming
    double_write_gate u_gate (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wrEn    (wrGate),
        .wrBit   (wb_dat_i[wake_event_pkg::BIT_MAC_GATE]),
        .gate_q  (macGate)
    );

    // Only the system clocks stop; RX and TX keep running
    wire sysClkEn_d = ~macGate;

    // Event pin
    pin_ctrl_if pinCtrl ();
    assign pinCtrl.request  = |routedNow;
    assign pinCtrl.pulseSel = pulseSel_q;
    assign pinCtrl.polarity = polarity_q;
    assign pinCtrl.pushPull = bufSel_q;
    assign pinCtrl.enable   = pinEn_q;

    event_pin_driver #(
        .PulseCycles (PulseCycles)
    ) u_pin (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ctrl     (pinCtrl),
        .pinOut_q (pinOut),
        .pinOe_q  (pinOe)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q       <= 1'b0;
            rdData_q    <= wake_event_pkg::REG_RESET;
            enSrc_q     <= '0;
            flag_q      <= '0;
            routed_q    <= '0;
            bufSel_q    <= 1'b0;
            pulseSel_q  <= 1'b0;
            polarity_q  <= 1'b0;
            pinEn_q     <= 1'b0;
            wakeIrq_q   <= 1'b0;
            irqMask_q   <= 1'b0;
            irq_q       <= 1'b0;
            sysClkEn_q  <= 1'b1;
            rxTxClkEn_q <= 1'b1;
        end
        else
        begin
            ack_q       <= ack_d;
            rdData_q    <= rdData_d;
            enSrc_q     <= enSrc_d;
            flag_q      <= flag_d;
            routed_q    <= routedNow;
            bufSel_q    <= bufSel_d;
            pulseSel_q  <= pulseSel_d;
            polarity_q  <= polarity_d;
            pinEn_q     <= pinEn_d;
            wakeIrq_q   <= wakeIrq_d;
            irqMask_q   <= irqMask_d;
            irq_q       <= irq_d;
            sysClkEn_q  <= sysClkEn_d;
            rxTxClkEn_q <= 1'b1;
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdData_q;
    assign macSysClkEn  = sysClkEn_q;
    assign macRxTxClkEn = rxTxClkEn_q;
    assign wakeEventOut = pinOut;
    assign wakeEventOe  = pinOe;
    assign irq          = irq_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_clock_gate_stop : assert property (macGate |=> !macSysClkEn && macRxTxClkEn)
        else $error("MAC system clock still enabled or RX/TX clock stopped");
    a_flag_b_sets : assert property (portBEvent |=> flag_q[1])
        else $error("Port B event did not set its flag");
    a_flag_a_sticks : assert property (portAEvent && flag_q[0] |=> flag_q[0])
        else $error("Port A flag cleared while event live");
    a_route_port_b : assert property (routedRise[1] |=> wakeIrq_q)
        else $error("Enabled port B event did not raise wake flag");
    a_route_port_a : assert property (
        portAEvent && enSrc_q[0] && !flag_q[0] && !enWr[0] |=> ##1 wakeIrq_q)
        else $error("Enabled port A event did not raise wake flag");
    a_route_host : assert property (routedRise[2] |=> wakeIrq_q)
        else $error("Enabled host MAC wake did not raise wake flag");
    // Fresh request only; a spent pulse keeps the request up with the pin idle
    a_pin_follows : assert property (
        pinCtrl.request && !(|routed_q) && !pinCtrl.asserted && pinEn_q && bufSel_q
        && polarity_q && !wrCtrl |=> ##1 wakeEventOut)
        else $error("Routed event did not drive the event pin");
    a_pin_open_drain : assert property (
        !bufSel_q && !pinEn_q && !wrCtrl |=> !wakeEventOe)
        else $error("Disabled open-drain pin is driving");
    // Enable flop lags the buffer select by one cycle
    a_pin_release : assert property (
        !pinCtrl.request ##1 !pinCtrl.request |=> !(wakeEventOe && !$past(bufSel_q)))
        else $error("Event pin still asserted after sources cleared");
    a_rsvd_zero : assert property (
        wb_ack_o && !wb_we_i && selCtrl
        |-> (wb_dat_o & wake_event_pkg::CTRL_RSVD_MASK) == '0)
        else $error("Reserved control bits read non-zero");
    a_irq_level : assert property (wakeIrq_q && irqMask_q |=> irq)
        else $error("Unmasked wake flag did not raise irq");
endmodule

// >>> sim/wake_pin_listener.sv
// Host-side wake input that listens to the event pin.
// Assumes a pull-up on the wire and that the bench tells it the pin style in use.
`timescale 1ns/10ps
module wake_pin_listener (
    input  wire logic        ref_clk,
    input  wire logic        pinOut,
    input  wire logic        pinOe,
    input  wire logic        pushPull,
    input  wire logic        activeHigh,
    input  wire logic        clrCnt,
    output logic             pinActive,
    output logic [15:0]      activeCnt
);
    logic line;

    // Released wire floats up, so an undriven pin reads inactive except when set to push-pull active-high
    assign line      = pinOe ? pinOut : 1'b1;
    assign pinActive = pushPull ? (line == activeHigh) : !line;

    always_ff @(posedge ref_clk)
    begin
        if (clrCnt)
            activeCnt <= 16'h0000;
        else if (pinActive)
            activeCnt <= activeCnt + 16'h0001;
    end
endmodule

// >>> sim/wake_event_pme_control_tb.sv
// Self-checking bench for the wake-event register slice.
// Assumes the listener model resolves the event pin and counts its active cycles.
`timescale 1ns/10ps
module wake_event_pme_control_tb;
    localparam int unsigned PC = 8;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] wdat    = 32'h0000_0000;
    logic [2:0]  ev      = 3'h0;
    logic        cfgPush = 1'b0;
    logic        cfgPol  = 1'b0;
    logic        clrCnt  = 1'b1;
    logic [31:0] rdat;
    logic        ack;
    logic        sysEn;
    logic        rxTxEn;
    logic        pinOut;
    logic        pinOe;
    logic        irq;
    logic        pinAct;
    logic [15:0] actCnt;
    int          error_cnt = 0;
    int          checked   = 0;
    int          cycles    = 0;

    always #5 ref_clk = ~ref_clk;

    wake_event_pme_control #(.PulseCycles(PC)) wake_event_pme_control_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .portAEvent(ev[0]), .portBEvent(ev[1]), .hostMacWakeEvent(ev[2]),
        .macSysClkEn(sysEn), .macRxTxClkEn(rxTxEn), .wakeEventOut(pinOut),
        .wakeEventOe(pinOe), .irq(irq));

    wake_pin_listener wake_pin_listener_i (
        .ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe), .pushPull(cfgPush),
        .activeHigh(cfgPol), .clrCnt(clrCnt), .pinActive(pinAct), .activeCnt(actCnt));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Whole run is under a thousand cycles; this ceiling only catches a hang
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
            chk("ack", 32'h0000_0001, 32'(ack));
    endtask

    // Gate model: a one only counts as the second in a row of lane-2 writes of one
    function automatic logic [1:0] gateNext(logic g, logic c, logic [3:0] s, logic b);
        if (!s[2])
            return {g, c};
        return b ? {g | c, 1'b1} : 2'b00;
    endfunction

    initial
    begin
        logic [31:0] r;
        logic [31:0] v;
        logic [31:0] cfg;
        logic [31:0] flg;
        logic [3:0]  s;
        logic        b, gateM, cntM, en, pp, pul, pe, mk, act;
        int unsigned i;
        void'($urandom(32'h6A84E1C6));
        gateM = 1'b0;
        cntM  = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wb(1'b0, wake_event_pkg::OFS_CTRL, 4'hF, 32'h0, r);
        chk("control reset", 32'h0000_0000, r);
        wb(1'b0, wake_event_pkg::OFS_STATUS, 4'hF, 32'h0, r);
        chk("status reset", 32'h0000_0000, r);
        wb(1'b0, 8'h0C, 4'hF, 32'h0, r);
        chk("unmapped read", 32'h0000_0000, r);
        for (int k = 0; k < 4; k++)
        begin
            v = $urandom & 32'h0000_FFDF;
            wb(1'b1, wake_event_pkg::OFS_CTRL, 4'hF, v, r);
            wb(1'b0, wake_event_pkg::OFS_CTRL, 4'hF, 32'h0, r);
            chk("reserved bits", v & 32'h0000_C24E, r);
        end
        for (int k = 0; k < 20; k++)
        begin
            b = (k < 2 || k == 3) ? 1'b1 : (k == 2 ? 1'b0 : 1'($urandom % 2));
            s = (k < 4) ? 4'hF : 4'($urandom);
            wb(1'b1, wake_event_pkg::OFS_CTRL, s, 32'(b) << 18, r);
            {gateM, cntM} = gateNext(gateM, cntM, s, b);
            wb(1'b0, wake_event_pkg::OFS_CTRL, 4'hF, 32'h0, r);
            chk("gate bit", 32'(gateM), 32'(r[18]));
            chk("sys clk en", 32'(!gateM), 32'(sysEn));
            chk("rx tx clk en", 32'h0000_0001, 32'(rxTxEn));
        end
        wb(1'b1, wake_event_pkg::OFS_CTRL, 4'hF, 32'h0, r);
        for (int k = 0; k < 12; k++)
        begin
            i   = k % 3;
            en  = (k < 4) ? 1'b1 : 1'($urandom % 2);
            pe  = (k < 4) ? 1'b1 : 1'($urandom % 2);
            pp  = (k < 4) ? 1'(k % 2) : 1'($urandom % 2);
            pul = (k < 4) ? 1'(k / 2) : 1'($urandom % 2);
            mk  = 1'($urandom % 2);
            cfgPush <= pp;
            cfgPol  <= (k < 4) ? 1'(k / 2) : 1'($urandom % 2);
            @(posedge ref_clk);
            flg = 32'h1 << wake_event_pkg::FLAG_BIT[i];
            cfg = (32'(en) << wake_event_pkg::EN_BIT[i]) | (32'(pp) << 6) | (32'(pul) << 3)
                | (32'(cfgPol) << 2) | (32'(pe) << 1);
            wb(1'b1, wake_event_pkg::OFS_CTRL, 4'hF, cfg, r);
            wb(1'b1, wake_event_pkg::OFS_MASK, 4'hF, 32'(mk), r);
            clrCnt <= 1'b1;
            @(posedge ref_clk);
            clrCnt <= 1'b0;
            ev[i]  <= 1'b1;
            repeat (20) @(posedge ref_clk);
            act = en & pe;
            chk("pin active", 32'(act & !pul), 32'(pinAct));
            if (pul)
                chk("pulse length", act ? PC : 0, 32'(actCnt));
            chk("irq", 32'(en & mk), 32'(irq));
            wb(1'b1, wake_event_pkg::OFS_CTRL, 4'hF, cfg | flg, r);
            wb(1'b0, wake_event_pkg::OFS_CTRL, 4'hF, 32'h0, r);
            chk("flag held", cfg | flg, r);
            wb(1'b0, wake_event_pkg::OFS_STATUS, 4'hF, 32'h0, r);
            chk("wake irq flag", 32'(en), r);
            ev[i] <= 1'b0;
            repeat (2) @(posedge ref_clk);
            wb(1'b1, wake_event_pkg::OFS_CTRL, 4'hF, cfg | flg, r);
            wb(1'b0, wake_event_pkg::OFS_CTRL, 4'hF, 32'h0, r);
            chk("flag cleared", cfg, r);
            repeat (3) @(posedge ref_clk);
            chk("pin released", 32'h0, 32'(pinAct));
            wb(1'b1, wake_event_pkg::OFS_STATUS, 4'hF, 32'h1, r);
            wb(1'b0, wake_event_pkg::OFS_STATUS, 4'hF, 32'h0, r);
            chk("status cleared", 32'h0, r);
            chk("irq cleared", 32'h0, 32'(irq));
        end
        wrap_up();
    end
endmodule
